// ---- design/cfg_ctrl_map.svh ----
// Constant map for the configuration-stage control block
// Behaviour
// - In a shared chain, hold user mode until every device reports complete.
// - After configuring, drive chain_enable_out low to start the next device.
// - After successful JTAG configuration, drive chain_enable_out low.
// - Disabled optional pins act as user I/O, tri-stated with pull-up while configuring; the code gives no optional pin a user I/O role.
// - With the start-up clock option, time initialization from the external clock.
// - Derive config_clock_out from the start-up clock when that source is selected.
// - While restart request is low, leave init-done released.
// - Drive init-done low once its option bit loads in the first frame.
// - When initialization finishes, release init-done and enter user mode.
// - With calibration gating on, hold init-done release until termination calibrated.
// - Global output enable low tri-states every I/O; high leaves them as programmed.
// - Global register clear low clears every user register; high leaves them as programmed.
// - Restart request, internal or external, acts as a configuration reset.
`ifndef CFG_CTRL_MAP_SVH
`define CFG_CTRL_MAP_SVH
`define INIT_CYCLES      16'h0020
`define INIT_CNT_W       16
`define DIVIDE_HALF      4'h2
`define DIV_W            4
`define USER_IO_W        8
`define SYNC_W           3
`define CLEAR_VAL        8'h00
`endif

// ---- design/cfg_ctrl_pkg.sv ----
// Types shared by the configuration-stage control block
package cfg_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_LOAD    = 3'b001,
    ST_WAITALL = 3'b011,
    ST_INIT    = 3'b010,
    ST_USER    = 3'b110
  } cfg_state_t;
endpackage : cfg_ctrl_pkg

// ---- design/pin_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic rst_val_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] stage_r;

  // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  // Reset to the pin's idle level, so no false change follows reset
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stage_r <= {3{rst_val_i}};
    end else begin
      stage_r <= {stage_r[1:0], pin_i};
    end
  end

  // Output follows once the two later stages agree
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      level_o <= rst_val_i;
    end else if (stage_r[1] == stage_r[2]) begin
      level_o <= stage_r[2];
    end
  end
endmodule : pin_sync

// ---- design/cfg_ctrl.sv ----
// Configuration-stage control: chain enable, init-done, global pins
`timescale 1ns/1ps
`include "cfg_ctrl_map.svh"
module cfg_ctrl (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      config_restart_request_n_i,
  input  wire logic                      internal_restart_i,
  input  wire logic                      chip_enable_in_n_i,
  input  wire logic                      config_frame0_loaded_i,
  input  wire logic                      config_data_done_i,
  input  wire logic                      jtag_config_done_i,
  input  wire logic                      config_complete_line_i,
  output logic                           config_complete_line_oe_o,
  input  wire logic                      config_status_line_i,
  output logic                           config_status_line_oe_o,
  output logic                           chain_enable_out_o,
  input  wire logic                      user_startup_clock_i,
  input  wire logic                      opt_startup_clock_en_i,
  input  wire logic                      opt_config_clock_out_from_user_clk_i,
  output logic                           config_clock_out_o,
  input  wire logic                      opt_init_done_en_i,
  input  wire logic                      opt_cal_gate_en_i,
  input  wire logic                      termination_calibrated_i,
  output logic                           init_done_o,
  output logic                           init_done_oe_o,
  input  wire logic                      opt_global_oe_en_i,
  input  wire logic                      global_output_enable_i,
  input  wire logic                      opt_global_clr_en_i,
  input  wire logic                      global_register_clear_n_i,
  input  wire logic [`USER_IO_W-1:0]     user_io_out_i,
  input  wire logic [`USER_IO_W-1:0]     user_io_oe_i,
  input  wire logic [`USER_IO_W-1:0]     user_reg_d_i,
  output logic [`USER_IO_W-1:0]          user_io_out_o,
  output logic [`USER_IO_W-1:0]          user_io_oe_o,
  output logic [`USER_IO_W-1:0]          user_io_pullup_o,
  output logic [`USER_IO_W-1:0]          user_reg_q_o,
  output logic                           user_mode_o,
  output cfg_ctrl_pkg::cfg_state_t       state_o
);
  import cfg_ctrl_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic restart_n_s;
  logic complete_s;
  logic status_s;
  logic ce_n_s;
  logic uclk_s;
  logic goe_s;
  logic gclr_n_s;
  logic cal_s;

  // Reset levels match each pin's idle state, so reset release is no restart
  pin_sync u_sync_restart (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b1),
    .pin_i(config_restart_request_n_i), .level_o(restart_n_s));
  pin_sync u_sync_complete (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
    .pin_i(config_complete_line_i), .level_o(complete_s));
  pin_sync u_sync_status (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b1),
    .pin_i(config_status_line_i), .level_o(status_s));
  pin_sync u_sync_ce (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b1),
    .pin_i(chip_enable_in_n_i), .level_o(ce_n_s));
  pin_sync u_sync_uclk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
    .pin_i(user_startup_clock_i), .level_o(uclk_s));
  pin_sync u_sync_goe (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b1),
    .pin_i(global_output_enable_i), .level_o(goe_s));
  pin_sync u_sync_gclr (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b1),
    .pin_i(global_register_clear_n_i), .level_o(gclr_n_s));
  pin_sync u_sync_cal (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
    .pin_i(termination_calibrated_i), .level_o(cal_s));

  // ************************************************************
  // Restart and start-up clock tick
  // ************************************************************
  logic restart_w;
  logic uclk_d_r;
  logic init_tick_w;

  // External pin low or internal request both restart configuration
  assign restart_w = !restart_n_s || internal_restart_i;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      uclk_d_r <= 1'b0;
    end else begin
      uclk_d_r <= uclk_s;
    end
  end

  // Start-up clock is oversampled, so it must run well below sys_clk
  assign init_tick_w = opt_startup_clock_en_i ? (uclk_s && !uclk_d_r) : 1'b1;

  // ************************************************************
  // Configuration state machine
  // ************************************************************
  cfg_state_t state_r;
  cfg_state_t state_nxt;
  logic [`INIT_CNT_W-1:0] init_cnt_r;
  logic init_en_r;
  logic chain_done_r;
  logic init_finished_w;

  assign init_finished_w = (init_cnt_r == `INIT_CYCLES);

  // Next state; shared-line wait holds every device until all report complete
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: begin
        if (!ce_n_s && status_s) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (config_data_done_i || jtag_config_done_i) begin
          state_nxt = ST_WAITALL;
        end
      end
      ST_WAITALL: begin
        if (complete_s) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_finished_w && (!opt_cal_gate_en_i || cal_s)) begin
          state_nxt = ST_USER;
        end
      end
      ST_USER: begin
        state_nxt = ST_USER;
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (restart_w) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Initialization counter paced by the selected start-up clock
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || state_r != ST_INIT) begin
      init_cnt_r <= '0;
    end else if (init_tick_w && !init_finished_w) begin
      init_cnt_r <= `INIT_CNT_W'(init_cnt_r + 1'b1);
    end
  end

  // Init-done option bit latched from the first configuration frame
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || restart_w) begin
      init_en_r <= 1'b0;
    end else if (state_r == ST_LOAD && config_frame0_loaded_i && opt_init_done_en_i) begin
      init_en_r <= 1'b1;
    end
  end

  // Chain enable goes low once this device is configured, by any path
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || restart_w) begin
      chain_done_r <= 1'b0;
    end else if (state_r == ST_LOAD && (config_data_done_i || jtag_config_done_i)) begin
      chain_done_r <= 1'b1;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  // Completion line open-drain: held low until this device is done
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      config_complete_line_oe_o <= 1'b1;
      config_status_line_oe_o   <= 1'b1;
      chain_enable_out_o        <= 1'b1;
      user_mode_o               <= 1'b0;
    end else begin
      config_complete_line_oe_o <= !chain_done_r;
      config_status_line_oe_o   <= restart_w;
      chain_enable_out_o        <= !chain_done_r;
      user_mode_o               <= (state_r == ST_USER);
    end
  end

  // Init-done pulls low only; released level comes from the board pull-up
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      init_done_oe_o <= 1'b0;
    end else begin
      init_done_oe_o <= init_en_r && (state_r != ST_USER) && !restart_w;
    end
  end
  assign init_done_o = 1'b0;

  // Configuration clock: start-up clock passed through, or system clock divided by four
  logic [`DIV_W-1:0] div_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      div_cnt_r          <= '0;
      config_clock_out_o <= 1'b0;
    end else if (opt_config_clock_out_from_user_clk_i) begin
      config_clock_out_o <= uclk_s;
    end else if (div_cnt_r == `DIVIDE_HALF - 1'b1) begin
      div_cnt_r          <= '0;
      config_clock_out_o <= !config_clock_out_o;
    end else begin
      div_cnt_r <= `DIV_W'(div_cnt_r + 1'b1);
    end
  end

  // ************************************************************
  // Global output enable and register clear
  // ************************************************************
  // User I/O tri-stated with pull-up until user mode, then gated by global OE
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      user_io_out_o    <= `CLEAR_VAL;
      user_io_oe_o     <= `CLEAR_VAL;
      user_io_pullup_o <= ~`CLEAR_VAL;
    end else if (state_r != ST_USER) begin
      user_io_out_o    <= `CLEAR_VAL;
      user_io_oe_o     <= `CLEAR_VAL;
      user_io_pullup_o <= ~`CLEAR_VAL;
    end else begin
      user_io_out_o    <= user_io_out_i;
      user_io_oe_o     <= (opt_global_oe_en_i && !goe_s) ? `CLEAR_VAL : user_io_oe_i;
      user_io_pullup_o <= `CLEAR_VAL;
    end
  end

  // Global clear overrides user registers while low
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || (opt_global_clr_en_i && !gclr_n_s)) begin
      user_reg_q_o <= `CLEAR_VAL;
    end else begin
      user_reg_q_o <= user_reg_d_i;
    end
  end

  assign state_o = state_r;
endmodule : cfg_ctrl

// ---- tb/cfg_ctrl_props.sv ----
// Port-level checks for the configuration-stage control block
`timescale 1ns/1ps
`include "cfg_ctrl_map.svh"
module cfg_ctrl_props
  import cfg_ctrl_pkg::*;
(
  input wire logic                  sys_clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  config_restart_request_n_i,
  input wire logic                  config_frame0_loaded_i,
  input wire logic                  config_data_done_i,
  input wire logic                  jtag_config_done_i,
  input wire logic                  config_complete_line_i,
  input wire logic                  chain_enable_out_o,
  input wire logic                  opt_init_done_en_i,
  input wire logic                  opt_cal_gate_en_i,
  input wire logic                  termination_calibrated_i,
  input wire logic                  init_done_o,
  input wire logic                  init_done_oe_o,
  input wire logic                  opt_global_oe_en_i,
  input wire logic                  global_output_enable_i,
  input wire logic                  opt_global_clr_en_i,
  input wire logic                  global_register_clear_n_i,
  input wire logic [`USER_IO_W-1:0] user_io_oe_o,
  input wire logic [`USER_IO_W-1:0] user_reg_q_o,
  input wire logic                  user_mode_o,
  input wire cfg_ctrl_pkg::cfg_state_t state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****
  // Restart and init-done
  // ****
  // Eight cycles covers the pin synchroniser plus the output register
  sequence s_rst; !config_restart_request_n_i [*8]; endsequence
  property p_od; init_done_oe_o |-> !init_done_o; endproperty
  a_od: assert property (p_od) else $error("init-done driven high");
  property p_rel; s_rst |-> !init_done_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("init-done pulled during restart");
  property p_rst; s_rst |-> chain_enable_out_o && !user_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("restart did not reset");
  property p_low; config_frame0_loaded_i && opt_init_done_en_i && state_o == ST_LOAD
    |-> ##[1:2] init_done_oe_o; endproperty
  a_low: assert property (p_low) else $error("init-done not pulled low");
  property p_up; $rose(user_mode_o) |-> !init_done_oe_o; endproperty
  a_up: assert property (p_up) else $error("user mode with init-done low");
  // ****
  // Chain and global pins
  // ****
  property p_cen; (config_data_done_i || jtag_config_done_i) && state_o == ST_LOAD
    |-> ##[1:2] !chain_enable_out_o; endproperty
  a_cen: assert property (p_cen) else $error("chain enable not driven");
  property p_all; (!config_complete_line_i) [*8] |-> !$rose(user_mode_o); endproperty
  a_all: assert property (p_all) else $error("user mode before chain done");
  property p_cal; (opt_cal_gate_en_i && !termination_calibrated_i) [*8]
    |-> !$rose(user_mode_o); endproperty
  a_cal: assert property (p_cal) else $error("user mode before calibration");
  property p_goe; (opt_global_oe_en_i && !global_output_enable_i) [*8]
    |-> user_io_oe_o == 8'h00; endproperty
  a_goe: assert property (p_goe) else $error("outputs not tri-stated");
  property p_clr; (opt_global_clr_en_i && !global_register_clear_n_i) [*8]
    |-> user_reg_q_o == `CLEAR_VAL; endproperty
  a_clr: assert property (p_clr) else $error("registers not cleared");
  c_user: cover property ($rose(user_mode_o));
  c_chain: cover property ($fell(chain_enable_out_o));
  c_init: cover property ($rose(init_done_oe_o));
endmodule : cfg_ctrl_props
bind cfg_ctrl cfg_ctrl_props cfg_ctrl_props_i (.*);

// ---- tb/chain_peer.sv ----
// Model of the chained peer device and the board monitor on the shared lines
`timescale 1ns/1ps
module chain_peer (
  input  wire logic sys_clk_i,
  input  wire logic peer_done_i,
  input  wire logic complete_oe_i,
  input  wire logic status_oe_i,
  input  wire logic init_oe_i,
  input  wire logic init_drv_i,
  output logic      complete_line_o,
  output logic      status_line_o,
  output logic      init_line_o,
  output logic      init_rise_o
);
  logic init_prev = 1'b1;
  // Pulled-up shared lines; the peer holds complete low until it is configured too
  assign complete_line_o = !complete_oe_i && peer_done_i;
  assign status_line_o = !status_oe_i;
  assign init_line_o = init_oe_i ? init_drv_i : 1'b1;
  // Monitor flags a low-to-high edge, so a line that never went low reports nothing
  always @(posedge sys_clk_i) begin
    init_rise_o <= init_line_o && !init_prev;
    init_prev <= init_line_o;
  end
endmodule : chain_peer

// ---- tb/test_cfg_ctrl.sv ----
// Self-checking bench for the configuration-stage control block
`timescale 1ns/1ps
`include "cfg_ctrl_map.svh"
module test_cfg_ctrl;
  import cfg_ctrl_pkg::*;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, config_restart_request_n_i = 1'b1;
  logic internal_restart_i = 1'b0, chip_enable_in_n_i = 1'b1, config_frame0_loaded_i = 1'b0;
  logic config_data_done_i = 1'b0, jtag_config_done_i = 1'b0, config_complete_line_i;
  logic config_status_line_i, user_startup_clock_i = 1'b0, opt_startup_clock_en_i = 1'b0;
  logic opt_config_clock_out_from_user_clk_i = 1'b0, opt_init_done_en_i = 1'b0, opt_cal_gate_en_i = 1'b0;
  logic termination_calibrated_i = 1'b0, opt_global_oe_en_i = 1'b0;
  logic global_output_enable_i = 1'b1, opt_global_clr_en_i = 1'b0;
  logic global_register_clear_n_i = 1'b1, config_complete_line_oe_o, config_status_line_oe_o;
  logic [`USER_IO_W-1:0] user_io_out_i = 8'h00, user_io_oe_i = 8'h00, user_reg_d_i = 8'h00;
  logic [`USER_IO_W-1:0] user_io_out_o, user_io_oe_o, user_io_pullup_o, user_reg_q_o;
  logic chain_enable_out_o, config_clock_out_o, init_done_o, init_done_oe_o, user_mode_o;
  cfg_state_t state_o;
  logic peer_done = 1'b0, init_line, init_rise, ucl_run = 1'b0, prev_cen = 1'b1;
  logic prev_um = 1'b0, config_clock_out_seen = 1'b0, prev_rst = 1'b0;
  logic [`USER_IO_W-1:0] last_out = 8'h00, last_d = 8'h00;
  integer config_clock_out_hi = 0;
  logic [3:0] ucnt = 4'h0;
  logic [1:0] exp_q[$];
  integer bad_count = 0, num_checks = 0, seed = 60;
  always #20 sys_clk_i = ~sys_clk_i;
  cfg_ctrl cfg_ctrl_i (.*);
  chain_peer chain_peer_i (.sys_clk_i(sys_clk_i), .peer_done_i(peer_done),
    .complete_oe_i(config_complete_line_oe_o), .status_oe_i(config_status_line_oe_o),
    .init_oe_i(init_done_oe_o), .init_drv_i(init_done_o),
    .complete_line_o(config_complete_line_i), .status_line_o(config_status_line_i),
    .init_line_o(init_line), .init_rise_o(init_rise));
  // Random user traffic, plus a start-up clock well below an eighth of the system rate
  always @(posedge sys_clk_i) begin
    user_io_out_i <= 8'($random(seed));
    user_io_oe_i <= 8'($random(seed));
    user_reg_d_i <= 8'($random(seed));
    ucnt <= ucnt + 4'h1;
    user_startup_clock_i <= ucl_run & ucnt[3];
  end
  task check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task close_out;
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick
  task pop(input logic [1:0] seen);
    logic [1:0] want;
    want = (exp_q.size() != 0) ? exp_q.pop_front() : 2'h0;
    check({6'h0, seen}, {6'h0, want});
  endtask : pop
  // Bounded wait until every noted event has been seen
  task wait_q(input int n);
    repeat (n) if (exp_q.size() != 0) @(posedge sys_clk_i);
    if (exp_q.size() != 0) check(8'h00, 8'h01);
    exp_q.delete();
  endtask : wait_q
  task load_frame;
    repeat (20) if (state_o !== ST_LOAD) @(posedge sys_clk_i);
    config_frame0_loaded_i <= 1'b1;
    tick(1);
    config_frame0_loaded_i <= 1'b0;
    tick(3);
  endtask : load_frame
  // Events: 1 chain enable fell, 2 user mode rose, 3 monitor saw init-done rise
  always @(negedge sys_clk_i) begin
    if (prev_cen === 1'b1 && chain_enable_out_o === 1'b0) pop(2'h1);
    if (prev_um === 1'b0 && user_mode_o === 1'b1) pop(2'h2);
    if (init_rise === 1'b1) pop(2'h3);
    // In user mode the outputs carry what user logic drove one edge earlier
    if (user_mode_o === 1'b1) check(user_io_out_o, last_out);
    if (prev_rst === 1'b1 && opt_global_clr_en_i === 1'b0) check(user_reg_q_o, last_d);
    last_out = user_io_out_i;
    last_d = user_reg_d_i;
    prev_rst = reset_n_i;
    prev_cen = chain_enable_out_o;
    prev_um = user_mode_o;
    // The divider never stays high four cycles; the start-up clock does
    config_clock_out_hi = (config_clock_out_o === 1'b1) ? config_clock_out_hi + 1 : 0;
    if (config_clock_out_hi == 4) config_clock_out_seen = 1'b1;
  end
  initial begin
    tick(4);
    reset_n_i <= 1'b1;
    opt_init_done_en_i <= 1'b1;
    opt_cal_gate_en_i <= 1'b1;
    chip_enable_in_n_i <= 1'b0;
    load_frame();
    check({7'h0, init_line}, 8'h00);
    check(user_io_pullup_o, 8'hff);
    check(user_io_oe_o, 8'h00);
    exp_q.push_back(2'h1);
    config_data_done_i <= 1'b1;
    tick(1);
    config_data_done_i <= 1'b0;
    wait_q(10);
    tick(20);
    check({7'h0, user_mode_o}, 8'h00);
    peer_done <= 1'b1;
    tick(80);
    check({7'h0, user_mode_o}, 8'h00);
    exp_q.push_back(2'h2);
    exp_q.push_back(2'h3);
    termination_calibrated_i <= 1'b1;
    wait_q(100);
    check({7'h0, init_line}, 8'h01);
    opt_global_oe_en_i <= 1'b1;
    global_output_enable_i <= 1'b0;
    opt_global_clr_en_i <= 1'b1;
    global_register_clear_n_i <= 1'b0;
    tick(10);
    check(user_io_oe_o, 8'h00);
    check(user_reg_q_o, `CLEAR_VAL);
    global_output_enable_i <= 1'b1;
    global_register_clear_n_i <= 1'b1;
    config_restart_request_n_i <= 1'b0;
    tick(10);
    check({6'h0, chain_enable_out_o, user_mode_o}, 8'h02);
    check({7'h0, init_line}, 8'h01);
    // Second pass over JTAG with chip enable grounded, start-up clock, no gating
    opt_init_done_en_i <= 1'b0;
    opt_cal_gate_en_i <= 1'b0;
    termination_calibrated_i <= 1'b0;
    opt_startup_clock_en_i <= 1'b1;
    opt_config_clock_out_from_user_clk_i <= 1'b1;
    ucl_run <= 1'b1;
    config_restart_request_n_i <= 1'b1;
    peer_done <= 1'b1; // Peer stays released, so the lines act as isolated
    config_clock_out_seen = 1'b0;
    load_frame();
    exp_q.push_back(2'h1);
    jtag_config_done_i <= 1'b1;
    tick(1);
    jtag_config_done_i <= 1'b0;
    wait_q(10);
    tick(100);
    check({7'h0, user_mode_o}, 8'h00);
    exp_q.push_back(2'h2);
    wait_q(900);
    check({7'h0, init_line}, 8'h01);
    check({7'h0, config_clock_out_seen}, 8'h01);
    internal_restart_i <= 1'b1;
    tick(10);
    check({7'h0, user_mode_o}, 8'h00);
    close_out();
  end
  // Watchdog sized well past the longest expected pass
  initial begin
    tick(4000);
    bad_count++;
    close_out();
  end
endmodule : test_cfg_ctrl
